// *** src/hds_dest_ctrl.sv ***
// hds_dest_ctrl: connection continuation, status word and wide pairing of a destination controller
// assumes error pulses and stored-word pulses from the datapath on core_clk,
// and link pins from the source clocked by hippi_clk
//
// Operation
// RULE1 - ready counter adds count, saturates 32
// RULE2 - counter decrements when burst ends
// RULE3 - each ready pulse grants one burst
// RULE4 - address reload only when idle
// RULE5 - disconnect function drops connect
// RULE6 - listed errors raise interrupt, drop connect
// RULE7 - request, segment, packet entry raise interrupt
// RULE8 - buffer parity, lost function: no interrupt
// RULE9 - channel and link share buffer concurrently
// RULE10 - software keeps address ranges apart
// RULE11 - pair via per-controller wide clear
// RULE12 - wide mode commands go to master
// RULE13 - unpair: master, slave, then clear both
// RULE14 - wide mode addresses are 64-bit words
// RULE15 - channel 64-bit words, i-field 32 bits
// RULE16 - both halves run own sequencer
// RULE17 - master syncs clock, fans out controls
// RULE18 - status read returns loopback, wide, zeros
// RULE19 - capable units: 26 sequence, 24 parity
// RULE20 - status read clears marked flags
// RULE21 - bits 11..6 packet count
// RULE22 - bits 5..0 outstanding ready count
// RULE23 - packet, connect, request, icb, capable, segment
// RULE24 - loopback follows source partner
// RULE25 - counters clear on clear or connect
// RULE26 - errors zero after clear
`timescale 1ns/1ps
module hds_dest_ctrl (
  // clocks and reset
  input wire logic core_clk,
  input wire logic hippi_clk,
  input wire logic rst,
  // foreground function port
  input wire logic func_valid,
  input wire hds_pkg::hds_func_s func,
  output logic resp_valid,
  output logic [31:0] resp_data,
  // datapath events
  input wire logic word_stored,
  input wire logic hippi_par_err,
  input wire logic llrc_err,
  input wire logic fifo_ovf_err,
  input wire logic buf_par_err,
  // partner and pairing
  input wire logic loopback_in,
  input wire logic icb_in,
  output logic icb_out,
  output logic wide_mode,
  output logic [12:0] dev_addr,
  output logic intr_resp,
  // source link
  input wire logic request_in,
  input wire logic packet_in,
  input wire logic burst_in,
  output logic connect_out,
  output logic ready_out
);
  import hds_pkg::*;

  function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s > {1'b0, READY_MAX}) ? READY_MAX : s[5:0];
  endfunction

  // ****************************************
  // link domain
  // ****************************************
  logic [1:0] req_s, pkt_s, bst_s;
  logic [1:0] conn_s, loop_s, rtg_s;
  logic req_q, pkt_q, bst_q;
  logic [8:0] bcnt, next_bcnt;
  logic short_seen, next_short_seen;
  logic rtg_seen, next_rtg_seen;
  logic next_ready;
  hds_evt_s evt_tgl, next_evt_tgl;
  logic conn_req, rdy_tgl;

  // RULE17 sample controls once
  always_ff @(negedge hippi_clk or posedge rst) begin
    if (rst) begin
      req_s <= 2'h0;
      pkt_s <= 2'h0;
      bst_s <= 2'h0;
      conn_s <= 2'h0;
      loop_s <= 2'h0;
      rtg_s <= 2'h0;
    end else begin
      req_s <= {req_s[0], request_in};
      pkt_s <= {pkt_s[0], packet_in};
      bst_s <= {bst_s[0], burst_in};
      conn_s <= {conn_s[0], conn_req};
      loop_s <= {loop_s[0], loopback_in};
      rtg_s <= {rtg_s[0], rdy_tgl};
    end
  end

  logic l_req, l_pkt, l_bst, l_conn;
  always_comb begin
    l_req = req_s[1] & ~loop_s[1];
    l_pkt = pkt_s[1] & ~loop_s[1];
    l_bst = bst_s[1] & ~loop_s[1];
    l_conn = conn_s[1] & ~loop_s[1];
    next_evt_tgl = evt_tgl;
    next_bcnt = l_bst ? ((bcnt == BURST_WORDS + 9'h1) ? bcnt : bcnt + 9'h1) : 9'h0;
    next_short_seen = short_seen;
    // RULE3 one pulse per grant
    next_rtg_seen = rtg_s[1];
    next_ready = (rtg_s[1] != rtg_seen) & l_conn;
    // RULE2 burst end event
    if (bst_q & ~l_bst) begin
      next_evt_tgl.burst_end = ~evt_tgl.burst_end;
      if (bcnt < BURST_WORDS) begin
        if (short_seen) next_evt_tgl.multi_short = ~evt_tgl.multi_short;
        next_short_seen = 1'b1;
      end
    end
    if (pkt_q & ~l_pkt) begin
      next_evt_tgl.pkt_end = ~evt_tgl.pkt_end;
      next_short_seen = 1'b0;
    end
    // long only while still high past a full burst
    if (l_bst & (bcnt == BURST_WORDS)) next_evt_tgl.long_burst = ~evt_tgl.long_burst;
    if (req_q & ~l_req & l_conn) next_evt_tgl.src_disc = ~evt_tgl.src_disc;
    if (((l_pkt | l_bst) & ~l_req) | (l_bst & ~l_pkt)) begin
      next_evt_tgl.seq_disc = ~evt_tgl.seq_disc;
    end else if (((l_pkt | l_bst) & ~l_conn) | (l_pkt & l_bst & ~pkt_q & ~bst_q) |
                 (~l_pkt & ~l_bst & pkt_q & bst_q & l_req)) begin
      next_evt_tgl.seq_err = ~evt_tgl.seq_err;
    end
  end

  always_ff @(negedge hippi_clk or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      pkt_q <= 1'b0;
      bst_q <= 1'b0;
      bcnt <= 9'h0;
      short_seen <= 1'b0;
      rtg_seen <= 1'b0;
      ready_out <= 1'b0;
      connect_out <= 1'b0;
      evt_tgl <= '0;
    end else begin
      req_q <= l_req;
      pkt_q <= l_pkt;
      bst_q <= l_bst;
      bcnt <= next_bcnt;
      short_seen <= next_short_seen;
      rtg_seen <= next_rtg_seen;
      ready_out <= next_ready;
      connect_out <= l_conn;
      evt_tgl <= next_evt_tgl;
    end
  end

  // ****************************************
  // core domain crossing
  // ****************************************
  hds_evt_s ev1, ev2, ev3, ev;
  logic [1:0] c_req_s, c_pkt_s, icb_s, c_loop_s;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ev1 <= '0;
      ev2 <= '0;
      ev3 <= '0;
      c_req_s <= 2'h0;
      c_pkt_s <= 2'h0;
      icb_s <= 2'h0;
      c_loop_s <= 2'h0;
    end else begin
      ev1 <= evt_tgl;
      ev2 <= ev1;
      ev3 <= ev2;
      c_req_s <= {c_req_s[0], req_q};
      c_pkt_s <= {c_pkt_s[0], pkt_q};
      icb_s <= {icb_s[0], icb_in};
      c_loop_s <= {c_loop_s[0], loopback_in};
    end
  end
  assign ev = ev2 ^ ev3;

  // ****************************************
  // core state
  // ****************************************
  logic [ADDR_W-1:0] pfile [PFILE_DEPTH];
  logic [5:0] wptr, next_wptr, rptr, next_rptr;
  logic [5:0] rdy_cnt, next_rdy_cnt, pkt_cnt, next_pkt_cnt, rdy_pend, next_rdy_pend;
  logic [ADDR_W-1:0] next_dev_addr;
  logic next_conn_req, next_rdy_tgl, rdy_busy, next_rdy_busy, rtg_ack;
  logic rtg_seen_m, rtg_seen_c;
  logic next_wide, next_intr, req_prev, next_req_prev, next_resp_valid;
  logic [31:0] next_resp_data;
  hds_status_s st, next_flags, flags;
  logic clr, rd_stat, pf_write;

  // RULE18 status word assembly
  always_comb begin
    st = flags;
    st.loopback = c_loop_s[1];
    st.wide = wide_mode;
    st.zero = 2'h0;
    // RULE19 capable unit positions
    st.err26 = WIDE_CAPABLE ? flags.err26 : flags.err24;
    st.err24 = WIDE_CAPABLE ? flags.err24 : flags.err26;
    // RULE23 live link and buffer state
    st.packet = c_pkt_s[1];
    st.connect = conn_req;
    st.request = c_req_s[1];
    st.icb_in = icb_s[1];
    st.capable = WIDE_CAPABLE;
    st.segment = dev_addr[SEG_BIT];
    // RULE21 packet count field
    st.pkt_cnt = pkt_cnt;
    // RULE22 ready count field
    st.rdy_cnt = rdy_cnt;
  end

  always_comb begin
    clr = func_valid & (func.code == FN_CLEAR);
    rd_stat = func_valid & (func.code == FN_READ_STATUS);
    pf_write = ev.pkt_end;
    next_flags = flags;
    next_conn_req = conn_req;
    next_wide = wide_mode;
    next_intr = intr_resp;
    next_rdy_cnt = rdy_cnt;
    next_pkt_cnt = pkt_cnt;
    next_rdy_pend = rdy_pend;
    next_rdy_busy = rdy_busy;
    next_rdy_tgl = rdy_tgl;
    next_dev_addr = dev_addr;
    next_wptr = pf_write ? wptr + 6'h1 : wptr;
    next_rptr = rptr;
    next_req_prev = c_req_s[1];
    next_resp_valid = func_valid;
    next_resp_data = 32'h0;
    // RULE9 link words advance independently of channel traffic
    // RULE15 one count per stored word
    if (word_stored) next_dev_addr = dev_addr + 13'h1;
    // RULE20 read clears marked flags
    if (rd_stat) begin
      next_resp_data = st;
      next_intr = 1'b0;
      next_flags.pfile_ovf = 1'b0;
      next_flags.llrc = 1'b0;
      next_flags.err26 = 1'b0;
      next_flags.long_burst = 1'b0;
      next_flags.multi_short = 1'b0;
      next_flags.src_disc = 1'b0;
      next_flags.fifo_ovf = 1'b0;
      next_flags.lost_fn = 1'b0;
    end
    if (func_valid) begin
      case (func.code)
        FN_ANSWER, FN_REJECT: begin
          if (~c_req_s[1] | conn_req) next_flags.lost_fn = 1'b1;
          else next_conn_req = 1'b1;
        end
        // RULE5 destination disconnect
        FN_DISCONNECT: begin
          if (~conn_req) next_flags.lost_fn = 1'b1;
          next_conn_req = 1'b0;
        end
        FN_READ_PFILE: begin
          next_resp_data = {19'h0, pfile[rptr]};
          if (pkt_cnt != 6'h0) begin
            next_rptr = rptr + 6'h1;
            next_pkt_cnt = pkt_cnt - 6'h1;
          end else begin
            next_resp_data[15] = 1'b1;
          end
        end
        // RULE4 reload only with no readys outstanding
        // RULE14 address loaded from param bits 12..0 the same way in either mode
        FN_SET_ADDR: begin
          next_intr = 1'b0;
          if (rdy_cnt != 6'h0) next_flags.lost_fn = 1'b1;
          else next_dev_addr = func.param[ADDR_W-1:0];
        end
        // RULE1 saturating ready add
        FN_SEND_READY: begin
          if (~conn_req) begin
            next_flags.lost_fn = 1'b1;
          end else begin
            next_rdy_cnt = sat_add(rdy_cnt, func.param[5:0]);
            next_rdy_pend = rdy_pend + (next_rdy_cnt - rdy_cnt);
          end
        end
        default: begin
        end
      endcase
    end
    // RULE3 hand each grant to the link
    if (rdy_busy & (rtg_ack == rdy_tgl)) begin
      next_rdy_busy = 1'b0;
    end else if (~rdy_busy & (rdy_pend != 6'h0)) begin
      next_rdy_tgl = ~rdy_tgl;
      next_rdy_busy = 1'b1;
      next_rdy_pend = next_rdy_pend - 6'h1;
    end
    // RULE2 burst received
    if (ev.burst_end & (next_rdy_cnt != 6'h0)) next_rdy_cnt = next_rdy_cnt - 6'h1;
    if (pf_write) begin
      if (pkt_cnt == PKT_MAX) next_flags.pfile_ovf = 1'b1;
      else next_pkt_cnt = next_pkt_cnt + 6'h1;
    end
    // RULE6 errors set flags and interrupt; all but the sequence error also drop connect
    if (ev.seq_err | ev.seq_disc) next_flags.err26 = 1'b1;
    if (hippi_par_err) next_flags.err24 = 1'b1;
    if (llrc_err) next_flags.llrc = 1'b1;
    if (ev.long_burst) next_flags.long_burst = 1'b1;
    if (ev.multi_short) next_flags.multi_short = 1'b1;
    if (ev.src_disc) next_flags.src_disc = 1'b1;
    if (fifo_ovf_err) next_flags.fifo_ovf = 1'b1;
    if ((pf_write & (pkt_cnt == PKT_MAX)) | ev.seq_disc | hippi_par_err | llrc_err |
        ev.long_burst | ev.multi_short | ev.src_disc | fifo_ovf_err) begin
      next_conn_req = 1'b0;
      next_intr = 1'b1;
    end
    if (ev.seq_err) next_intr = 1'b1;
    // RULE8 no interrupt for these
    if (buf_par_err) next_flags.buf_par = 1'b1;
    // RULE7 request change, segment change, packet entry
    if ((c_req_s[1] != req_prev) | (next_dev_addr[SEG_BIT] != dev_addr[SEG_BIT]) | pf_write) begin
      next_intr = 1'b1;
    end
    // RULE11 wide mode taken from clear parameter
    // RULE26 clear empties every flag
    if (clr) begin
      next_flags = '0;
      next_conn_req = 1'b0;
      next_wide = func.param[WIDE_BIT];
      next_intr = 1'b0;
      next_wptr = 6'h0;
      next_rptr = 6'h0;
    end
    // RULE25 clear counters on clear or new connect
    if (clr | (next_conn_req & ~conn_req)) begin
      next_rdy_cnt = 6'h0;
      next_pkt_cnt = 6'h0;
      next_rdy_pend = 6'h0;
      next_dev_addr = '0;
      next_wptr = 6'h0;
      next_rptr = 6'h0;
    end
  end

  // RULE16 own sequencer per controller
  // RULE24 loopback follows partner level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags <= '0;
      conn_req <= 1'b0;
      wide_mode <= 1'b0;
      icb_out <= 1'b0;
      intr_resp <= 1'b0;
      rdy_cnt <= 6'h0;
      pkt_cnt <= 6'h0;
      rdy_pend <= 6'h0;
      rdy_busy <= 1'b0;
      rdy_tgl <= 1'b0;
      rtg_ack <= 1'b0;
      dev_addr <= '0;
      wptr <= 6'h0;
      rptr <= 6'h0;
      req_prev <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= 32'h0;
    end else begin
      flags <= next_flags;
      conn_req <= next_conn_req;
      wide_mode <= next_wide;
      icb_out <= next_wide;
      intr_resp <= next_intr;
      rdy_cnt <= next_rdy_cnt;
      pkt_cnt <= next_pkt_cnt;
      rdy_pend <= next_rdy_pend;
      rdy_busy <= next_rdy_busy;
      rdy_tgl <= next_rdy_tgl;
      rtg_ack <= rtg_seen_c;
      dev_addr <= next_dev_addr;
      wptr <= next_wptr;
      rptr <= next_rptr;
      req_prev <= next_req_prev;
      resp_valid <= next_resp_valid;
      resp_data <= next_resp_data;
    end
  end

  // ready acknowledge crosses back through two stages
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rtg_seen_m <= 1'b0;
      rtg_seen_c <= 1'b0;
    end else begin
      rtg_seen_m <= rtg_seen;
      rtg_seen_c <= rtg_seen_m;
    end
  end

  always_ff @(posedge core_clk) begin
    if (pf_write) pfile[wptr] <= dev_addr;
  end

endmodule

// *** src/hds_pkg.sv ***
// hds_pkg: constants and carriers for the destination status and control block
// assumes a foreground function port on core_clk and a source link on its own clock
package hds_pkg;

  // ****************************************
  // function codes
  // ****************************************
  localparam logic [5:0] FN_CLEAR = 6'h00;
  localparam logic [5:0] FN_ANSWER = 6'h01;
  localparam logic [5:0] FN_REJECT = 6'h02;
  localparam logic [5:0] FN_DISCONNECT = 6'h03;
  localparam logic [5:0] FN_READ_PFILE = 6'h06;
  localparam logic [5:0] FN_READ_STATUS = 6'h07;
  localparam logic [5:0] FN_SET_ADDR = 6'h0a;
  localparam logic [5:0] FN_SEND_READY = 6'h0b;

  // ****************************************
  // field positions and limits
  // ****************************************
  localparam int WIDE_BIT = 0;
  localparam logic [5:0] READY_MAX = 6'h20;
  localparam logic [5:0] PKT_MAX = 6'h3f;
  localparam logic [8:0] BURST_WORDS = 9'h100;
  localparam int ADDR_W = 13;
  localparam int SEG_BIT = 12;
  localparam int PFILE_DEPTH = 64;
  localparam logic WIDE_CAPABLE = 1'b1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [5:0] code;
    logic [31:0] param;
  } hds_func_s;

  // toggles, one per link event
  typedef struct packed {
    logic burst_end;
    logic pkt_end;
    logic seq_err;
    logic seq_disc;
    logic long_burst;
    logic multi_short;
    logic src_disc;
  } hds_evt_s;

  typedef struct packed {
    logic loopback;
    logic wide;
    logic [1:0] zero;
    logic pfile_ovf;
    logic err26;
    logic llrc;
    logic err24;
    logic long_burst;
    logic multi_short;
    logic src_disc;
    logic buf_par;
    logic fifo_ovf;
    logic lost_fn;
    logic packet;
    logic connect;
    logic request;
    logic icb_in;
    logic capable;
    logic segment;
    logic [5:0] pkt_cnt;
    logic [5:0] rdy_cnt;
  } hds_status_s;

endpackage

// *** sim/hds_dest_ctrl_asserts.sv ***
// hds_dest_ctrl_asserts: port-level checks of the destination status and control block
// assumes binding to hds_dest_ctrl with all ports visible
`timescale 1ns/1ps
module hds_dest_ctrl_asserts (
  // clocks and reset
  input wire logic core_clk,
  input wire logic hippi_clk,
  input wire logic rst,
  // function port
  input wire logic func_valid,
  input wire hds_pkg::hds_func_s func,
  input wire logic resp_valid,
  input wire logic [31:0] resp_data,
  // datapath events
  input wire logic word_stored,
  input wire logic hippi_par_err,
  input wire logic llrc_err,
  input wire logic fifo_ovf_err,
  input wire logic buf_par_err,
  // partner and pairing
  input wire logic loopback_in,
  input wire logic icb_in,
  input wire logic icb_out,
  input wire logic wide_mode,
  input wire logic [12:0] dev_addr,
  input wire logic intr_resp,
  // source link
  input wire logic request_in,
  input wire logic packet_in,
  input wire logic burst_in,
  input wire logic connect_out,
  input wire logic ready_out
);
  import hds_pkg::*;
  // ****
  // checks
  // ****
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic rd_stat;
  logic quiet;
  assign rd_stat = func_valid && func.code == FN_READ_STATUS;
  assign quiet = !llrc_err && !fifo_ovf_err;

  property p_resp;
    func_valid |=> resp_valid;
  endproperty
  a_resp: assert property (p_resp) else $error("no response after function");
  property p_fixed_bits;
    rd_stat |=> resp_data[29:28] == 2'h0 && resp_data[30] == wide_mode && resp_data[13] == WIDE_CAPABLE;
  endproperty
  a_fixed_bits: assert property (p_fixed_bits) else $error("status fixed bits wrong");
  property p_rdy_sat;
    rd_stat |=> resp_data[5:0] <= READY_MAX;
  endproperty
  a_rdy_sat: assert property (p_rdy_sat) else $error("ready count above limit");
  property p_read_clear;
    (rd_stat && quiet) ##1 quiet ##1 (rd_stat && quiet) |=> resp_data[25] == 1'b0 && resp_data[19:18] == 2'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags survived status read");
  property p_llrc_intr;
    (llrc_err && !func_valid) |-> ##[1:3] intr_resp;
  endproperty
  a_llrc_intr: assert property (p_llrc_intr) else $error("error did not enable interrupt");
  property p_disc;
    (func_valid && func.code == FN_DISCONNECT && connect_out) |-> ##[1:20] !connect_out;
  endproperty
  a_disc: assert property (p_disc) else $error("connect held after disconnect");
  property p_rdy_conn;
    ready_out |-> connect_out;
  endproperty
  a_rdy_conn: assert property (p_rdy_conn) else $error("ready without connection");
  property p_wide;
    (func_valid && func.code == FN_CLEAR) |-> ##2 wide_mode == $past(func.param[WIDE_BIT], 2) && icb_out == wide_mode;
  endproperty
  a_wide: assert property (p_wide) else $error("wide mode not taken from clear");
  property p_loop;
    loopback_in [*8] |-> !connect_out && !ready_out;
  endproperty
  a_loop: assert property (p_loop) else $error("link driven in loopback");
endmodule

// *** sim/hds_src_model.sv ***
// hds_src_model: source side of the link, sends one packet of bursts per request
// assumes a free-running link clock; changes its pins after the rising edge
`timescale 1ns/1ps
module hds_src_model (
  // control from bench
  input wire logic hippi_clk,
  input wire logic req,
  input wire logic [3:0] n_bursts,
  // link pins
  input wire logic connect_out,
  input wire logic ready_out,
  output logic request_in,
  output logic packet_in,
  output logic burst_in,
  output logic done
);
  int grants = 0;
  int used = 0;
  always @(posedge hippi_clk) begin
    if (ready_out === 1'b1) begin
      grants <= grants + 1;
    end
  end
  initial begin
    request_in = 1'b0;
    packet_in = 1'b0;
    burst_in = 1'b0;
    done = 1'b0;
    forever begin
      @(posedge hippi_clk);
      request_in <= req;
      if (!req) begin
        done <= 1'b0;
      end
      if (req && connect_out && !done) begin
        packet_in <= 1'b1;
        @(posedge hippi_clk);
        for (int b = 0; b < n_bursts; b++) begin
          while (grants == used) begin
            @(posedge hippi_clk);
          end
          used++;
          burst_in <= 1'b1;
          repeat (256) @(posedge hippi_clk);
          burst_in <= 1'b0;
          repeat (2) @(posedge hippi_clk);
        end
        packet_in <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule

// *** sim/test_hippi_destination_status_control.sv ***
// test_hippi_destination_status_control: function-level bench for hds_dest_ctrl
// assumes the source model on the link and the checker bound below
`timescale 1ns/1ps
module test_hippi_destination_status_control;
  import hds_pkg::*;
  logic core_clk, hippi_clk, rst, func_valid, resp_valid, word_stored, llrc_err, fifo_ovf_err, buf_par_err;
  logic loopback_in, icb_in, icb_out, wide_mode, intr_resp, request_in, packet_in, burst_in, connect_out, ready_out;
  logic src_req, src_done, hippi_par_err;
  logic [31:0] resp_data, rd;
  logic [12:0] dev_addr;
  hds_func_s func;
  int miscompares, check_count;

  hds_dest_ctrl i_hds_dest_ctrl (.core_clk, .hippi_clk, .rst, .func_valid, .func, .resp_valid, .resp_data,
    .word_stored, .hippi_par_err, .llrc_err, .fifo_ovf_err, .buf_par_err, .loopback_in, .icb_in, .icb_out,
    .wide_mode, .dev_addr, .intr_resp, .request_in, .packet_in, .burst_in, .connect_out, .ready_out);
  hds_src_model i_hds_src_model (.hippi_clk, .req(src_req), .n_bursts(4'h2), .connect_out, .ready_out,
    .request_in, .packet_in, .burst_in, .done(src_done));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    hippi_clk = 1'b0;
    #3.3;
    forever #7.5 hippi_clk = ~hippi_clk;
  end
  // ****
  // tasks
  // ****
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic fn(input logic [5:0] code, input logic [31:0] param);
    idle(1);
    func_valid = 1'b1;
    func = '{code, param};
    idle(1);
    func_valid = 1'b0;
    chk("resp_valid", {31'h0, resp_valid}, 32'h1);
    rd = resp_data;
  endtask
  task automatic st(input logic [31:0] exp);
    fn(FN_READ_STATUS, 32'h0);
    chk("status", rd, exp);
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    end_of_test();
  end
  // ****
  // tests
  // ****
  initial begin
    miscompares = 0;
    check_count = 0;
    {rst, func_valid, word_stored, llrc_err, fifo_ovf_err, buf_par_err} = 6'h20;
    {loopback_in, icb_in, src_req, hippi_par_err} = 4'h0;
    func = '0;
    idle(8);
    rst = 1'b0;
    st(32'h0000_2000);
    fn(FN_DISCONNECT, 32'h0);
    st(32'h0004_2000);
    st(32'h0000_2000);
    buf_par_err = 1'b1;
    idle(1);
    buf_par_err = 1'b0;
    idle(4);
    chk("intr_resp", {31'h0, intr_resp}, 32'h0);
    st(32'h0010_2000);
    hippi_par_err = 1'b1;
    idle(1);
    hippi_par_err = 1'b0;
    idle(4);
    chk("intr_resp", {31'h0, intr_resp}, 32'h1);
    st(32'h0110_2000);
    fn(FN_CLEAR, 32'h0);
    st(32'h0000_2000);
    {llrc_err, fifo_ovf_err} = 2'h3;
    idle(1);
    {llrc_err, fifo_ovf_err} = 2'h0;
    idle(4);
    chk("intr_resp", {31'h0, intr_resp}, 32'h1);
    st(32'h0208_2000);
    st(32'h0000_2000);
    chk("intr_resp", {31'h0, intr_resp}, 32'h0);
    src_req = 1'b1;
    idle(30);
    chk("intr_resp", {31'h0, intr_resp}, 32'h1);
    st(32'h0000_a000);
    fn(FN_ANSWER, 32'h0);
    for (int i = 0; i < 40 && connect_out !== 1'b1; i++) begin
      idle(1);
    end
    chk("connect_out", {31'h0, connect_out}, 32'h1);
    st(32'h0001_a000);
    repeat (5) begin
      word_stored = 1'b1;
      idle(1);
      word_stored = 1'b0;
      idle(1);
    end
    fn(FN_SEND_READY, 32'h28);
    st(32'h0003_a020);
    for (int i = 0; i < 3000 && src_done !== 1'b1; i++) begin
      idle(1);
    end
    chk("src_done", {31'h0, src_done}, 32'h1);
    idle(12);
    chk("dev_addr", {19'h0, dev_addr}, 32'h5);
    chk("intr_resp", {31'h0, intr_resp}, 32'h1);
    st(32'h0001_a05e);
    fn(FN_SET_ADDR, 32'h0);
    st(32'h0005_a05e);
    fn(FN_READ_PFILE, 32'h0);
    chk("pfile", {16'h0, rd[15:0]}, 32'h5);
    st(32'h0001_a01e);
    fn(FN_READ_PFILE, 32'h0);
    chk("pfile_empty", {31'h0, rd[15]}, 32'h1);
    fn(FN_DISCONNECT, 32'h0);
    for (int i = 0; i < 40 && connect_out !== 1'b0; i++) begin
      idle(1);
    end
    chk("connect_out", {31'h0, connect_out}, 32'h0);
    st(32'h0000_a01e);
    src_req = 1'b0;
    icb_in = 1'b1;
    idle(30);
    fn(FN_CLEAR, 32'h1);
    idle(4);
    chk("wide_mode", {31'h0, wide_mode}, 32'h1);
    chk("icb_out", {31'h0, icb_out}, 32'h1);
    st(32'h4000_6000);
    fn(FN_CLEAR, 32'h0);
    icb_in = 1'b0;
    loopback_in = 1'b1;
    idle(8);
    st(32'h8000_2000);
    end_of_test();
  end
endmodule

bind hds_dest_ctrl hds_dest_ctrl_asserts i_hds_dest_ctrl_asserts (.core_clk, .hippi_clk, .rst, .func_valid, .func,
  .resp_valid, .resp_data, .word_stored, .hippi_par_err, .llrc_err, .fifo_ovf_err, .buf_par_err, .loopback_in,
  .icb_in, .icb_out, .wide_mode, .dev_addr, .intr_resp, .request_in, .packet_in, .burst_in, .connect_out, .ready_out);
